// ==== verilog/pot_pkg.sv ====
// Shared constants for the quad potentiometer serial link
package pot_pkg;
	// Frame header
	localparam logic [3:0] DEV_ID = 4'h5;
	localparam logic [1:0] HDR_ZEROS = 2'h0;
	localparam logic [4:0] HDR_BITS = 5'h10;
	localparam logic [4:0] FULL_BITS = 5'h18;
	localparam logic [4:0] HDR_LAST = 5'h0f;
	localparam logic [4:0] DATA_LAST = 5'h17;

	// Instruction opcodes
	localparam logic [3:0] OP_RD_WIPER = 4'h9;
	localparam logic [3:0] OP_WR_WIPER = 4'ha;
	localparam logic [3:0] OP_RD_SLOT = 4'hb;
	localparam logic [3:0] OP_WR_SLOT = 4'hc;
	localparam logic [3:0] OP_SLOT_TO_WIPER = 4'hd;
	localparam logic [3:0] OP_WIPER_TO_SLOT = 4'he;
	localparam logic [3:0] OP_STEP = 4'h2;
	localparam logic [3:0] OP_ALL_TO_WIPER = 4'h1;
	localparam logic [3:0] OP_ALL_TO_SLOT = 4'h8;
	localparam logic [3:0] OP_STATUS = 4'h5;
	localparam logic [1:0] STATUS_POT = 2'h1;
	localparam logic [5:0] WIPER_MAX = 6'h3f;
	localparam logic [5:0] WIPER_MIN = 6'h0;
	localparam logic [5:0] WIPER_RESET = 6'h0;

	// Timing
	localparam int SYS_PERIOD_NS = 40;
	localparam int WRITE_CYCLE_NS = 10000;
	localparam int WRITE_CYCLES =
		(WRITE_CYCLE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam logic [8:0] WRITE_CNT = 9'(WRITE_CYCLES);
	localparam logic [1:0] SCLK_PHASE_LAST = 2'h1;

	// Host control registers
	localparam logic [3:0] CTRL_OFF = 4'h0;
	localparam logic [3:0] STATUS_OFF = 4'h4;
	localparam int CTRL_DATA_LSB = 0;
	localparam int CTRL_INSTR_LSB = 8;
	localparam int CTRL_ADDR_LSB = 16;
	localparam int CTRL_STEPS_LSB = 24;
	localparam int CTRL_DIR_BIT = 28;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_RX_LSB = 8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== verilog/pot_link_if.sv ====
// Serial link wires between the host and the potentiometer
interface pot_link_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso_out;
	logic miso_oe;
	logic miso;

	// Released line is pulled high
	assign miso = miso_oe ? miso_out : 1'b1;

	modport host (output sclk, output cs_n, output mosi, input miso);
	modport device (input sclk, input cs_n, input mosi,
		output miso_out, output miso_oe);
endinterface

// ==== verilog/sync2.sv ====
// Two-stage synchroniser for levels entering a clock domain
module sync2 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= INIT;
			q <= INIT;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// ==== verilog/pot_device.sv ====
// Potentiometer end of the serial link: decoder, wipers and stored slots
//
// Functional notes
// - Frame opens at select fall; identifier 0101.
// - Two zeros then chip address, matched.
// - Opcode 1001 returns selected wiper position.
// - Opcode 1010 loads third byte into wiper.
// - Opcode 1011 returns selected stored slot.
// - Opcode 1101 copies slot into wiper.
// - Opcode 1110 copies wiper into slot, writes.
// - Opcode 0010 steps selected wiper until deselect.
// - Opcode 0001 copies slots into all wipers.
// - Opcode 1000 copies all wipers into slots.
// - Input high steps up, low steps down.
// - Status returns write-in-progress in bit zero.
// - Slot writes hold busy for write time.
module pot_device (
	input wire logic sys_clk,
	input wire logic rstn,
	pot_link_if.device link,
	input wire logic [1:0] chip_addr_pins,
	output logic [3:0][5:0] wiper_pos,
	output logic write_busy
);
	// ------------------------------------------------------------
	// Link domain: bit counter and input shifter
	// ------------------------------------------------------------
	logic frame_rstn;
	logic [1:0] addr_q;
	logic wip_q;
	logic [4:0] bit_cnt_reg, bit_cnt_next;
	logic [14:0] in_reg, in_next;
	logic [15:0] hdr_w;
	logic hdr_ok;

	// Deselect clears the frame state without a clock edge
	assign frame_rstn = rstn & ~link.cs_n;

	sync2 #(
		.WIDTH(2),
		.INIT(2'h0)
	) addr_sync (
		.clk(link.sclk),
		.rstn(rstn),
		.d(chip_addr_pins),
		.q(addr_q)
	);

	sync2 #(
		.WIDTH(1),
		.INIT(1'b0)
	) wip_sync (
		.clk(link.sclk),
		.rstn(rstn),
		.d(write_busy),
		.q(wip_q)
	);

	assign hdr_w = {in_reg, link.mosi};
	assign hdr_ok = hdr_w[15:12] == pot_pkg::DEV_ID &&
		hdr_w[11:10] == pot_pkg::HDR_ZEROS &&
		hdr_w[9:8] == addr_q;

	always_comb begin
		bit_cnt_next = bit_cnt_reg;
		if (bit_cnt_reg != pot_pkg::FULL_BITS) begin
			bit_cnt_next = bit_cnt_reg + 5'h1;
		end
		in_next = {in_reg[13:0], link.mosi};
	end

	always_ff @(posedge link.sclk or negedge frame_rstn) begin
		if (!frame_rstn) begin
			bit_cnt_reg <= 5'h0;
			in_reg <= 15'h0;
		end else begin
			bit_cnt_reg <= bit_cnt_next;
			in_reg <= in_next;
		end
	end

	// ------------------------------------------------------------
	// Link domain: captured command, data byte and step toggles
	// ------------------------------------------------------------
	// These hold after deselect so the system side can read them
	logic [7:0] instr_reg, instr_next;
	logic match_reg, match_next;
	logic [5:0] data_reg, data_next;
	logic data_ok_reg, data_ok_next;
	logic up_tgl_reg, up_tgl_next;
	logic dn_tgl_reg, dn_tgl_next;
	logic [3:0] op;
	logic [1:0] slot_sel;
	logic [1:0] pot_sel;

	assign op = instr_reg[7:4];
	assign slot_sel = instr_reg[3:2];
	assign pot_sel = instr_reg[1:0];

	always_comb begin
		instr_next = instr_reg;
		match_next = match_reg;
		data_next = data_reg;
		data_ok_next = data_ok_reg;
		up_tgl_next = up_tgl_reg;
		dn_tgl_next = dn_tgl_reg;
		if (bit_cnt_reg == 5'h0) begin
			match_next = 1'b0;
			data_ok_next = 1'b0;
		end
		if (bit_cnt_reg == pot_pkg::HDR_LAST) begin
			match_next = hdr_ok;
			instr_next = hdr_w[7:0];
		end
		if (bit_cnt_reg == pot_pkg::DATA_LAST) begin
			data_next = hdr_w[5:0];
			data_ok_next = 1'b1;
		end
		if (bit_cnt_reg >= pot_pkg::HDR_BITS && match_reg &&
			op == pot_pkg::OP_STEP) begin
			if (link.mosi) begin
				up_tgl_next = ~up_tgl_reg;
			end else begin
				dn_tgl_next = ~dn_tgl_reg;
			end
		end
	end

	always_ff @(posedge link.sclk or negedge rstn) begin
		if (!rstn) begin
			instr_reg <= 8'h00;
			match_reg <= 1'b0;
			data_reg <= 6'h0;
			data_ok_reg <= 1'b0;
			up_tgl_reg <= 1'b0;
			dn_tgl_reg <= 1'b0;
		end else begin
			instr_reg <= instr_next;
			match_reg <= match_next;
			data_reg <= data_next;
			data_ok_reg <= data_ok_next;
			up_tgl_reg <= up_tgl_next;
			dn_tgl_reg <= dn_tgl_next;
		end
	end

	// ------------------------------------------------------------
	// Link domain: serial output on the falling edge
	// ------------------------------------------------------------
	// Wipers and slots only change while deselected or while
	// stepping, so reading them here during a read frame is safe
	logic [7:0] out_reg, out_next;
	logic oe_reg, oe_next;
	logic rd_op;
	logic [7:0] rd_byte;
	logic [3:0][5:0] wiper_reg, wiper_next;
	logic [15:0][5:0] slot_reg, slot_next;

	always_comb begin
		rd_op = 1'b0;
		rd_byte = 8'h00;
		case (op)
			pot_pkg::OP_RD_WIPER: begin
				rd_op = slot_sel == 2'h0;
				rd_byte = {2'h0, wiper_reg[pot_sel]};
			end
			pot_pkg::OP_RD_SLOT: begin
				rd_op = 1'b1;
				rd_byte = {2'h0, slot_reg[{slot_sel, pot_sel}]};
			end
			pot_pkg::OP_STATUS: begin
				rd_op = slot_sel == 2'h0 &&
					pot_sel == pot_pkg::STATUS_POT;
				rd_byte = {7'h00, wip_q};
			end
			default: begin
				rd_op = 1'b0;
			end
		endcase
		out_next = {out_reg[6:0], 1'b0};
		oe_next = oe_reg;
		if (bit_cnt_reg == pot_pkg::HDR_BITS && match_reg && rd_op) begin
			out_next = rd_byte;
			oe_next = 1'b1;
		end
	end

	always_ff @(negedge link.sclk or negedge frame_rstn) begin
		if (!frame_rstn) begin
			out_reg <= 8'h00;
			oe_reg <= 1'b0;
		end else begin
			out_reg <= out_next;
			oe_reg <= oe_next;
		end
	end

	assign link.miso_out = out_reg[7];
	assign link.miso_oe = oe_reg;

	// ------------------------------------------------------------
	// System domain: commits, stepping and the write timer
	// ------------------------------------------------------------
	logic cs_q;
	logic [1:0] tgl_q;
	logic cs_prev_reg;
	logic [1:0] tgl_prev_reg;
	logic [8:0] wr_cnt_reg, wr_cnt_next;
	logic busy_next;
	logic commit;
	logic up_evt;
	logic dn_evt;
	logic start_write;

	sync2 #(
		.WIDTH(1),
		.INIT(1'b1)
	) cs_sync (
		.clk(sys_clk),
		.rstn(rstn),
		.d(link.cs_n),
		.q(cs_q)
	);

	sync2 #(
		.WIDTH(2),
		.INIT(2'h0)
	) tgl_sync (
		.clk(sys_clk),
		.rstn(rstn),
		.d({up_tgl_reg, dn_tgl_reg}),
		.q(tgl_q)
	);

	// Captured command is static once the link clock has stopped
	assign commit = cs_q & ~cs_prev_reg & match_reg;
	assign up_evt = tgl_q[1] ^ tgl_prev_reg[1];
	assign dn_evt = tgl_q[0] ^ tgl_prev_reg[0];

	always_comb begin
		wiper_next = wiper_reg;
		slot_next = slot_reg;
		start_write = 1'b0;
		if (up_evt && !dn_evt && wiper_reg[pot_sel] != pot_pkg::WIPER_MAX) begin
			wiper_next[pot_sel] = wiper_reg[pot_sel] + 6'h1;
		end
		if (dn_evt && !up_evt && wiper_reg[pot_sel] != pot_pkg::WIPER_MIN) begin
			wiper_next[pot_sel] = wiper_reg[pot_sel] - 6'h1;
		end
		if (commit) begin
			case (op)
				pot_pkg::OP_WR_WIPER: begin
					if (slot_sel == 2'h0 && data_ok_reg) begin
						wiper_next[pot_sel] = data_reg;
					end
				end
				pot_pkg::OP_WR_SLOT: begin
					if (data_ok_reg) begin
						slot_next[{slot_sel, pot_sel}] = data_reg;
						start_write = 1'b1;
					end
				end
				pot_pkg::OP_SLOT_TO_WIPER: begin
					wiper_next[pot_sel] = slot_reg[{slot_sel, pot_sel}];
				end
				pot_pkg::OP_WIPER_TO_SLOT: begin
					slot_next[{slot_sel, pot_sel}] = wiper_reg[pot_sel];
					start_write = 1'b1;
				end
				pot_pkg::OP_ALL_TO_WIPER: begin
					if (pot_sel == 2'h0) begin
						for (int i = 0; i < 4; i++) begin
							wiper_next[i] = slot_reg[{slot_sel, 2'(i)}];
						end
					end
				end
				pot_pkg::OP_ALL_TO_SLOT: begin
					if (pot_sel == 2'h0) begin
						for (int i = 0; i < 4; i++) begin
							slot_next[{slot_sel, 2'(i)}] = wiper_reg[i];
						end
						start_write = 1'b1;
					end
				end
				default: begin
					start_write = 1'b0;
				end
			endcase
		end
		wr_cnt_next = wr_cnt_reg;
		if (start_write) begin
			wr_cnt_next = pot_pkg::WRITE_CNT;
		end else if (wr_cnt_reg != 9'h0) begin
			wr_cnt_next = wr_cnt_reg - 9'h1;
		end
		busy_next = wr_cnt_next != 9'h0;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cs_prev_reg <= 1'b1;
			tgl_prev_reg <= 2'h0;
			wiper_reg <= {4{pot_pkg::WIPER_RESET}};
			slot_reg <= {16{pot_pkg::WIPER_RESET}};
			wr_cnt_reg <= 9'h0;
			write_busy <= 1'b0;
			wiper_pos <= {4{pot_pkg::WIPER_RESET}};
		end else begin
			cs_prev_reg <= cs_q;
			tgl_prev_reg <= tgl_q;
			wiper_reg <= wiper_next;
			slot_reg <= slot_next;
			wr_cnt_reg <= wr_cnt_next;
			write_busy <= busy_next;
			wiper_pos <= wiper_next;
		end
	end
endmodule

// ==== verilog/pot_host.sv ====
// Host end: AXI4-Lite command registers driving the serial link
module pot_host (
	input wire logic sys_clk,
	input wire logic rstn,
	pot_link_if.host link,
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_LAST, H_GAP} hstate_type;

	// ------------------------------------------------------------
	// Register slave
	// ------------------------------------------------------------
	hstate_type st_reg, st_next;
	logic [7:0] rx_reg, rx_next;
	logic [31:0] ctrl_reg, ctrl_next;
	logic [3:0] waddr_reg, waddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic aw_have_reg, aw_have_next;
	logic w_have_reg, w_have_next;
	logic awready_next, wready_next, bvalid_next, arready_next, rvalid_next;
	logic [1:0] bresp_next, rresp_next;
	logic [31:0] rdata_next;
	logic start;

	always_comb begin
		awready_next = awready;
		wready_next = wready;
		bvalid_next = bvalid;
		bresp_next = bresp;
		arready_next = arready;
		rvalid_next = rvalid;
		rdata_next = rdata;
		rresp_next = rresp;
		waddr_next = waddr_reg;
		wdata_next = wdata_reg;
		aw_have_next = aw_have_reg;
		w_have_next = w_have_reg;
		ctrl_next = ctrl_reg;
		start = 1'b0;
		if (awvalid && awready) begin
			awready_next = 1'b0;
			aw_have_next = 1'b1;
			waddr_next = awaddr;
		end
		if (wvalid && wready) begin
			wready_next = 1'b0;
			w_have_next = 1'b1;
			for (int i = 0; i < 4; i++) begin
				wdata_next[8*i +: 8] = wstrb[i] ? wdata[8*i +: 8] : ctrl_reg[8*i +: 8];
			end
		end
		if (aw_have_reg && w_have_reg && !bvalid) begin
			aw_have_next = 1'b0;
			w_have_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = pot_pkg::RESP_SLVERR;
			if (waddr_reg == pot_pkg::CTRL_OFF) begin
				bresp_next = pot_pkg::RESP_OKAY;
				if (st_reg == H_IDLE) begin
					ctrl_next = wdata_reg;
					start = 1'b1;
				end
			end else if (waddr_reg == pot_pkg::STATUS_OFF) begin
				bresp_next = pot_pkg::RESP_OKAY;
			end
		end
		if (bvalid && bready) begin
			bvalid_next = 1'b0;
			awready_next = 1'b1;
			wready_next = 1'b1;
		end
		if (arvalid && arready) begin
			arready_next = 1'b0;
			rvalid_next = 1'b1;
			rresp_next = pot_pkg::RESP_OKAY;
			rdata_next = 32'h0000_0000;
			if (araddr == pot_pkg::CTRL_OFF) begin
				rdata_next = ctrl_reg;
			end else if (araddr == pot_pkg::STATUS_OFF) begin
				rdata_next[pot_pkg::STATUS_BUSY_BIT] = st_reg != H_IDLE;
				rdata_next[pot_pkg::STATUS_RX_LSB +: 8] = rx_reg;
			end else begin
				rresp_next = pot_pkg::RESP_SLVERR;
			end
		end
		if (rvalid && rready) begin
			rvalid_next = 1'b0;
			arready_next = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= pot_pkg::RESP_OKAY;
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= pot_pkg::RESP_OKAY;
			waddr_reg <= 4'h0;
			wdata_reg <= 32'h0000_0000;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			ctrl_reg <= pot_pkg::CTRL_RESET;
		end else begin
			awready <= awready_next;
			wready <= wready_next;
			bvalid <= bvalid_next;
			bresp <= bresp_next;
			arready <= arready_next;
			rvalid <= rvalid_next;
			rdata <= rdata_next;
			rresp <= rresp_next;
			waddr_reg <= waddr_next;
			wdata_reg <= wdata_next;
			aw_have_reg <= aw_have_next;
			w_have_reg <= w_have_next;
			ctrl_reg <= ctrl_next;
		end
	end

	// ------------------------------------------------------------
	// Serial master: link clock from a divider, mode 0 timing
	// ------------------------------------------------------------
	logic miso_q;
	logic [1:0] ph_reg, ph_next;
	logic sclk_reg, sclk_next, cs_n_reg, cs_n_next, mosi_reg, mosi_next;
	logic fill_reg, fill_next;
	logic [23:0] tx_reg, tx_next;
	logic [4:0] nbits_reg, nbits_next, cnt_reg, cnt_next;
	logic ph_end;
	logic [3:0] new_op;

	sync2 #(
		.WIDTH(1),
		.INIT(1'b1)
	) miso_sync (
		.clk(sys_clk),
		.rstn(rstn),
		.d(link.miso),
		.q(miso_q)
	);

	assign ph_end = ph_reg == pot_pkg::SCLK_PHASE_LAST;
	assign new_op = wdata_reg[pot_pkg::CTRL_INSTR_LSB + 4 +: 4];

	always_comb begin
		st_next = st_reg;
		ph_next = ph_end ? 2'h0 : ph_reg + 2'h1;
		sclk_next = sclk_reg;
		cs_n_next = cs_n_reg;
		mosi_next = mosi_reg;
		fill_next = fill_reg;
		tx_next = tx_reg;
		nbits_next = nbits_reg;
		cnt_next = cnt_reg;
		rx_next = rx_reg;
		case (st_reg)
			H_IDLE: begin
				ph_next = 2'h0;
				if (start) begin
					tx_next = {pot_pkg::DEV_ID, pot_pkg::HDR_ZEROS,
						wdata_reg[pot_pkg::CTRL_ADDR_LSB +: 2],
						wdata_reg[pot_pkg::CTRL_INSTR_LSB +: 8],
						wdata_reg[pot_pkg::CTRL_DATA_LSB +: 8]};
					mosi_next = pot_pkg::DEV_ID[3];
					cs_n_next = 1'b0;
					cnt_next = 5'h0;
					fill_next = 1'b0;
					case (new_op)
						pot_pkg::OP_RD_WIPER, pot_pkg::OP_WR_WIPER,
						pot_pkg::OP_RD_SLOT, pot_pkg::OP_WR_SLOT,
						pot_pkg::OP_STATUS: begin
							nbits_next = pot_pkg::FULL_BITS;
						end
						pot_pkg::OP_STEP: begin
							nbits_next = pot_pkg::HDR_BITS +
								{1'b0, wdata_reg[pot_pkg::CTRL_STEPS_LSB +: 4]};
							fill_next = wdata_reg[pot_pkg::CTRL_DIR_BIT];
							tx_next[7:0] = {8{fill_next}};
						end
						default: begin
							nbits_next = pot_pkg::HDR_BITS;
						end
					endcase
					st_next = H_SHIFT;
				end
			end
			H_SHIFT: begin
				if (ph_end && !sclk_reg) begin
					sclk_next = 1'b1;
				end else if (ph_end) begin
					sclk_next = 1'b0;
					rx_next = {rx_reg[6:0], miso_q};
					cnt_next = cnt_reg + 5'h1;
					tx_next = {tx_reg[22:0], fill_reg};
					mosi_next = tx_reg[22];
					if (cnt_next == nbits_reg) begin
						st_next = H_LAST;
					end
				end
			end
			H_LAST: begin
				if (ph_end) begin
					cs_n_next = 1'b1;
					st_next = H_GAP;
				end
			end
			H_GAP: begin
				if (ph_end) begin
					st_next = H_IDLE;
				end
			end
			default: begin
				st_next = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= H_IDLE;
			ph_reg <= 2'h0;
			sclk_reg <= 1'b0;
			cs_n_reg <= 1'b1;
			mosi_reg <= 1'b0;
			fill_reg <= 1'b0;
			tx_reg <= 24'h00_0000;
			nbits_reg <= 5'h0;
			cnt_reg <= 5'h0;
			rx_reg <= 8'h00;
		end else begin
			st_reg <= st_next;
			ph_reg <= ph_next;
			sclk_reg <= sclk_next;
			cs_n_reg <= cs_n_next;
			mosi_reg <= mosi_next;
			fill_reg <= fill_next;
			tx_reg <= tx_next;
			nbits_reg <= nbits_next;
			cnt_reg <= cnt_next;
			rx_reg <= rx_next;
		end
	end

	assign link.sclk = sclk_reg;
	assign link.cs_n = cs_n_reg;
	assign link.mosi = mosi_reg;
endmodule

// ==== bench/pot_link_chk.sv ====
// Protocol checker for the serial link between host and potentiometer
module pot_link_chk (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso_out,
	input wire logic miso_oe
);
	// ----------------------------------------
	// Frame position tracking
	// ----------------------------------------
	logic [5:0] bit_cnt_reg;
	logic [7:0] op_reg;
	logic is_rd;
	assign is_rd = op_reg[7:2] == 6'h24 || op_reg[7:4] == 4'hb ||
		op_reg == 8'h51;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			bit_cnt_reg <= 6'h0;
			op_reg <= 8'h0;
		end else if (cs_n) begin
			bit_cnt_reg <= 6'h0;
		end else if ($rose(sclk)) begin
			bit_cnt_reg <= bit_cnt_reg + 6'h1;
			if (bit_cnt_reg[5:3] == 3'h1) begin
				op_reg <= {op_reg[6:0], mosi};
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	chk_idle_sclk: assert property (cs_n |-> !sclk)
		else $error("serial clock active outside a frame");
	chk_sclk_half: assert property ($rose(sclk) |-> ##1 sclk ##1 !sclk)
		else $error("serial clock high phase not two cycles");
	chk_mosi_hold: assert property (sclk && $past(sclk) |-> $stable(mosi))
		else $error("host data moved during clock high phase");
	chk_id_bits: assert property ($rose(sclk) && bit_cnt_reg < 6'd4 |->
		mosi == pot_pkg::DEV_ID[2'd3 - bit_cnt_reg[1:0]])
		else $error("device type bit wrong");
	chk_hdr_zeros: assert property ($rose(sclk) &&
		bit_cnt_reg inside {6'd4, 6'd5} |-> !mosi)
		else $error("header zero bits not zero");
	chk_cs_gap: assert property ($rose(cs_n) |-> cs_n ##1 cs_n)
		else $error("select high time too short");
	chk_cs_tail: assert property ($fell(sclk) |-> !cs_n ##1 !cs_n)
		else $error("select rose too soon after last clock");
	chk_miso_release: assert property (cs_n |-> !miso_oe)
		else $error("device drives data line while deselected");
	chk_miso_read: assert property (miso_oe |->
		is_rd && bit_cnt_reg >= 6'd16)
		else $error("device drives data line outside a read byte");
	chk_lead_zeros: assert property ($rose(sclk) && miso_oe &&
		bit_cnt_reg < 6'd18 |-> !miso_out)
		else $error("leading data bits not zero");
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench: host and device ends joined over the serial link
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, rstn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, write_busy;
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp, pins;
	logic [3:0][5:0] wiper_pos;
	logic [5:0] wp[4];
	logic [5:0] sl[4][4];
	logic [1:0] bq[$];
	logic [33:0] rq[$];
	logic [31:0] mq[$];
	int miscompares, comparisons;

	pot_link_if link();
	pot_host pot_host_inst (.sys_clk(sys_clk), .rstn(rstn), .link(link),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));
	pot_device pot_device_inst (.sys_clk(sys_clk), .rstn(rstn), .link(link),
		.chip_addr_pins(pins), .wiper_pos(wiper_pos),
		.write_busy(write_busy));
	pot_link_chk pot_link_chk_inst (.sys_clk(sys_clk), .rstn(rstn),
		.sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi),
		.miso_out(link.miso_out), .miso_oe(link.miso_oe));

	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task automatic check(input string nm, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic hang();
		miscompares++;
		conclude();
	endtask

	task automatic check_wipers();
		for (int i = 0; i < 4; i++) begin
			check("wiper_pos", 32'(wiper_pos[i]), 32'(wp[i]));
		end
	endtask

	// Result monitor: oldest note against each response seen
	always @(posedge sys_clk) begin
		logic [33:0] e;
		logic [31:0] m;
		if (bvalid && bready) begin
			check("bresp", 32'(bresp), 32'(bq.pop_front()));
		end
		if (rvalid && rready) begin
			e = rq.pop_front();
			m = mq.pop_front();
			check("rdata", rdata & m, e[31:0] & m);
			check("rresp", 32'(rresp), 32'(e[33:32]));
		end
	end

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] r);
		int n;
		@(posedge sys_clk);
		bq.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 300; n++) begin
			@(posedge sys_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		if (n == 300) hang();
	endtask

	task automatic axi_read(input logic [3:0] a, input logic [33:0] e,
		input logic [31:0] m, output logic [31:0] d);
		int n;
		@(posedge sys_clk);
		rq.push_back(e);
		mq.push_back(m);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 300; n++) begin
			@(posedge sys_clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		rready <= 1'b0;
		if (n == 300) hang();
	endtask

	function automatic logic [31:0] mk(input logic [3:0] op,
		input logic [1:0] s, p, a, input logic [7:0] d);
		return {14'h0, a, op, s, p, d};
	endfunction

	// One frame: start, wait for idle, read back control and received byte
	task automatic frame(input logic [31:0] c, input logic [7:0] rx);
		int n;
		axi_write(pot_pkg::CTRL_OFF, c, pot_pkg::RESP_OKAY);
		for (n = 0; n < 400; n++) begin
			axi_read(pot_pkg::STATUS_OFF, 34'h0, 32'h0, rd);
			if (rd[pot_pkg::STATUS_BUSY_BIT] === 1'b0) break;
		end
		if (n == 400) hang();
		repeat (8) @(posedge sys_clk);
		axi_read(pot_pkg::CTRL_OFF, {pot_pkg::RESP_OKAY, c}, '1, rd);
		axi_read(pot_pkg::STATUS_OFF, {pot_pkg::RESP_OKAY, 16'h0, rx, 8'h0},
			32'h0000_ff01, rd);
	endtask

	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	initial begin
		int p, c, e;
		int st[4];
		int cn[4];
		logic [5:0] v;
		st = '{60, 3, 0, 40};
		cn = '{15, 5, 0, 15};
		{rstn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{awaddr, araddr, wdata} = 40'h0;
		wstrb = 4'hf;
		miscompares = 0;
		comparisons = 0;
		rd = $urandom(32'h8837_e306);
		pins = 2'($urandom());
		wp = '{default: 6'h0};
		sl = '{default: '{default: 6'h0}};
		repeat (12) @(posedge sys_clk);
		rstn <= 1'b1;
		axi_write(4'h8, 32'h0, pot_pkg::RESP_SLVERR);
		axi_read(4'hc, {pot_pkg::RESP_SLVERR, 32'h0}, '1, rd);
		axi_write(pot_pkg::STATUS_OFF, '1, pot_pkg::RESP_OKAY);
		for (p = 0; p < 4; p++) begin
			v = 6'($urandom());
			wp[p] = v;
			frame(mk(pot_pkg::OP_WR_WIPER, 0, 2'(p), pins, {2'h0, v}), 8'hff);
			check_wipers();
			frame(mk(pot_pkg::OP_RD_WIPER, 0, 2'(p), pins, 0), {2'h0, v});
		end
		frame(mk(pot_pkg::OP_WR_WIPER, 0, 0, ~pins, 8'h15), 8'hff);
		frame(mk(pot_pkg::OP_RD_WIPER, 0, 0, ~pins, 0), 8'hff);
		check_wipers();
		for (p = 0; p < 16; p++) begin
			v = 6'($urandom());
			sl[p / 4][p % 4] = v;
			frame(mk(pot_pkg::OP_WR_SLOT, 2'(p), 2'(p / 4), pins, 8'(v)), 8'hff);
			if (p == 0) begin
				check("write_busy", 32'(write_busy), 32'h1);
				frame(mk(pot_pkg::OP_STATUS, 0, pot_pkg::STATUS_POT, pins, 0),
					8'h01);
			end
		end
		repeat (260) @(posedge sys_clk);
		check("write_busy", 32'(write_busy), 32'h0);
		frame(mk(pot_pkg::OP_STATUS, 0, pot_pkg::STATUS_POT, pins, 0), 8'h00);
		wp[1] = sl[1][2];
		frame(mk(pot_pkg::OP_SLOT_TO_WIPER, 2'h2, 2'h1, pins, 0), 8'hff);
		check_wipers();
		sl[3][0] = wp[3];
		frame(mk(pot_pkg::OP_WIPER_TO_SLOT, 2'h0, 2'h3, pins, 0), 8'hff);
		for (p = 0; p < 4; p++) wp[p] = sl[p][3];
		frame(mk(pot_pkg::OP_ALL_TO_WIPER, 2'h3, 2'h0, pins, 0), 8'hff);
		check_wipers();
		for (p = 0; p < 4; p++) sl[p][1] = wp[p];
		frame(mk(pot_pkg::OP_ALL_TO_SLOT, 2'h1, 2'h0, pins, 0), 8'hff);
		for (p = 0; p < 16; p++) begin
			frame(mk(pot_pkg::OP_RD_SLOT, 2'(p), 2'(p / 4), pins, 0),
				{2'h0, sl[p / 4][p % 4]});
		end
		st[2] = $urandom_range(47, 16);
		cn[2] = $urandom_range(15, 1);
		for (p = 0; p < 4; p++) begin
			c = cn[p];
			e = p % 2 ? st[p] - c : st[p] + c;
			e = e > 63 ? 63 : e < 0 ? 0 : e;
			frame(mk(pot_pkg::OP_WR_WIPER, 0, 2'(p), pins, 8'(st[p])), 8'hff);
			frame(mk(pot_pkg::OP_STEP, 2'(p), 2'(p), pins, 0) |
				{3'h0, p % 2 == 0, 4'(c), 24'h0}, 8'hff);
			wp[p] = 6'(e);
			check_wipers();
		end
		conclude();
	end
endmodule
